// file: sysctl_pkg.sv
// shared constants and carrier types for the cpu system control registers
package sysctl_pkg;

    // register offsets, register addressing space, set 1
    localparam logic [7:0] OFS_SYSTEM_FLAGS           = 8'hd5;
    localparam logic [7:0] OFS_INSTR_POINTER_HIGH     = 8'hda;
    localparam logic [7:0] OFS_INSTR_POINTER_LOW      = 8'hdb;
    localparam logic [7:0] OFS_INTERRUPT_LEVEL_MASK   = 8'hdd;
    localparam logic [7:0] OFS_EXTERNAL_MEMORY_TIMING = 8'hfe;

    // bank in which the memory timing register lives
    localparam logic       BANK_EXTERNAL_MEMORY_TIMING = 1'b0;

    // memory timing field positions
    localparam int EMT_WAIT_INPUT_BIT = 7;
    localparam int EMT_SLOW_BIT       = 6;
    localparam int EMT_PROG_WAIT_HI   = 5;
    localparam int EMT_PROG_WAIT_LO   = 4;
    localparam int EMT_DATA_WAIT_HI   = 3;
    localparam int EMT_DATA_WAIT_LO   = 2;
    localparam int EMT_STACK_BIT      = 1;

    // reset values
    localparam logic [7:0] RST_EXTERNAL_MEMORY_TIMING = 8'h7c;
    localparam logic [7:0] RST_SYSTEM_FLAGS           = 8'h00;
    localparam logic [7:0] RST_INTERRUPT_LEVEL_MASK   = 8'h00;
    localparam logic [7:0] RST_INSTR_POINTER_HIGH     = 8'h00;
    localparam logic [7:0] RST_INSTR_POINTER_LOW      = 8'h00;

    // answer for refused or unmapped reads
    localparam logic [7:0] READ_EMPTY = 8'h00;

    // timing: extra wait added by slow memory timing
    localparam logic [2:0] SLOW_EXTRA_WAIT = 3'h1;

    typedef enum logic [1:0]
    {
        MODE_REGISTER = 2'b00,
        MODE_INDIRECT = 2'b01,
        MODE_INDEXED  = 2'b10
    } addr_mode_t;

    typedef enum logic [1:0]
    {
        OP_NONE  = 2'b00,
        OP_ADD   = 2'b01,
        OP_SUB   = 2'b10,
        OP_LOGIC = 2'b11
    } alu_kind_t;

    typedef enum logic
    {
        ST_IDLE = 1'b0,
        ST_WAIT = 1'b1
    } wait_state_t;

    // flags register image, bit 7 first
    typedef struct packed
    {
        logic carry;
        logic zero;
        logic sign;
        logic overflow;
        logic decimal;
        logic half;
        logic fast_service_active_flag;
        logic bank;
    } flags_t;

    typedef struct packed
    {
        logic       wr;
        logic       rd;
        addr_mode_t mode;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // alu operation from the datapath: kind, operands and carry in; for logic ops a holds the result
    typedef struct packed
    {
        alu_kind_t  kind;
        logic [7:0] a;
        logic [7:0] b;
        logic       cin;
    } alu_req_t;

    typedef struct packed
    {
        logic start;
        logic is_data;
    } mem_req_t;

    typedef struct packed
    {
        logic       wait_input_enable;
        logic       slow_timing;
        logic [1:0] prog_wait;
        logic [1:0] data_wait;
        logic       stack_external;
    } mem_cfg_t;

endpackage

// file: flag_calc.sv
// arithmetic flag evaluation for one alu outcome
module flag_calc
(
    input  wire sysctl_pkg::alu_req_t req,
    input  wire sysctl_pkg::flags_t   cur,
    output sysctl_pkg::flags_t        next_flags
);
    import sysctl_pkg::*;

    logic [8:0] wide;
    logic [4:0] nib;
    logic [7:0] res;

    always_comb
    begin
        next_flags = cur;
        wide       = 9'h000;
        nib        = 5'h00;
        res        = req.a;
        case (req.kind)
            OP_ADD:
            begin
                wide = {1'b0, req.a} + {1'b0, req.b} + {8'h00, req.cin};
                nib  = {1'b0, req.a[3:0]} + {1'b0, req.b[3:0]} + {4'h0, req.cin};
                res  = wide[7:0];
                // R7 carry out of bit 7
                next_flags.carry    = wide[8];
                // R10 signed range exceeded
                next_flags.overflow = (req.a[7] == req.b[7]) && (res[7] != req.a[7]);
                // R11 addition recorded
                next_flags.decimal  = 1'b0;
                // R12 carry out of bit 3
                next_flags.half     = nib[4];
            end
            OP_SUB:
            begin
                wide = {1'b0, req.a} - {1'b0, req.b} - {8'h00, req.cin};
                nib  = {1'b0, req.a[3:0]} - {1'b0, req.b[3:0]} - {4'h0, req.cin};
                res  = wide[7:0];
                // R7 borrow into bit 7
                next_flags.carry    = wide[8];
                // R10 signed range exceeded
                next_flags.overflow = (req.a[7] != req.b[7]) && (res[7] != req.a[7]);
                // R11 subtraction recorded
                next_flags.decimal  = 1'b1;
                // R12 borrow into bit 3
                next_flags.half     = nib[4];
            end
            OP_LOGIC:
            begin
                // logic results cannot overflow
                next_flags.overflow = 1'b0;
            end
            default:
            begin
                res = req.a;
            end
        endcase
        if (req.kind != OP_NONE)
        begin
            // R8 zero result
            next_flags.zero = (res == 8'h00);
            // R9 copy result msb
            next_flags.sign = res[7];
        end
    end

endmodule

// file: cpu_system_control_registers.sv
// cpu system control registers: memory timing, flags, interrupt mask, instruction pointer
// Operation
// R1: bit 6 selects slow memory timing
// R2: bits 5:4 give program wait cycles
// R3: bits 3:2 give data wait cycles
// R4: bit 1 puts stack in external memory
// R5: software clears memory timing after reset
// R6: software leaves memory timing alone afterwards
// R7: carry flag from bit 7 carry/borrow
// R8: zero flag when result is zero
// R9: sign flag copies result msb
// R10: overflow flag outside -128..+127
// R11: decimal flag records add or subtract
// R12: half-carry from bit 3 carry/borrow
// R13: fast service flag set, cleared by return
// R14: bank flag set/cleared by bank instructions
// R15: register addressing mode access only
// R16: high byte holds pointer bits 15:8
// R17: mask bit n enables interrupt level n
module cpu_system_control_registers
#(
    parameter int IRQ_LEVELS = 8
)
(
    input  wire logic                    mclk,
    input  wire logic                    arst_n,
    input  wire sysctl_pkg::reg_req_t    reg_req,
    output sysctl_pkg::mem_cfg_t         mem_cfg,
    output logic [7:0]                   reg_rdata,
    output logic                         reg_rvalid,
    input  wire sysctl_pkg::alu_req_t    alu_req,
    input  wire logic                    fast_irq_enter,
    input  wire logic                    interrupt_return_instr,
    input  wire logic                    select_bank_zero_instr,
    input  wire logic                    select_bank_one_instr,
    input  wire logic                    ip_load,
    input  wire logic [15:0]             ip_value,
    input  wire logic [IRQ_LEVELS-1:0]   irq_request,
    output logic [IRQ_LEVELS-1:0]        irq_enabled,
    input  wire sysctl_pkg::mem_req_t    mem_req,
    output logic                         mem_stall,
    output sysctl_pkg::flags_t           flags,
    output logic [15:0]                  instr_pointer
);
    import sysctl_pkg::*;

    logic                  rst_meta_n;
    logic                  rst_n;
    logic [7:0]            external_memory_timing;
    flags_t                system_flags;
    flags_t                next_flags;
    logic [7:0]            interrupt_level_mask;
    logic [7:0]            instr_pointer_high;
    logic [7:0]            instr_pointer_low;
    logic                  reg_mode_ok;
    logic                  wr_ok;
    logic                  rd_ok;
    logic                  emt_visible;
    logic                  hit_emt;
    logic                  hit_flags;
    logic                  hit_iph;
    logic                  hit_ipl;
    logic                  hit_imr;
    logic [7:0]            next_rdata;
    wait_state_t           wait_state;
    logic [2:0]            wait_count;
    logic [2:0]            wait_need;
    logic [2:0]            wait_base;

    // reset release through two flops
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_meta_n <= 1'b0;
            rst_n      <= 1'b0;
        end
        else
        begin
            rst_meta_n <= 1'b1;
            rst_n      <= rst_meta_n;
        end
    end

    // R15 indirect and indexed accesses are ignored
    assign reg_mode_ok = (reg_req.mode == MODE_REGISTER);
    assign wr_ok       = reg_req.wr && reg_mode_ok;
    assign rd_ok       = reg_req.rd && reg_mode_ok;

    // memory timing register sits in bank 0 only
    assign emt_visible = (system_flags.bank == BANK_EXTERNAL_MEMORY_TIMING);
    assign hit_emt     = (reg_req.addr == OFS_EXTERNAL_MEMORY_TIMING) && emt_visible;
    assign hit_flags   = (reg_req.addr == OFS_SYSTEM_FLAGS);
    assign hit_iph     = (reg_req.addr == OFS_INSTR_POINTER_HIGH);
    assign hit_ipl     = (reg_req.addr == OFS_INSTR_POINTER_LOW);
    assign hit_imr     = (reg_req.addr == OFS_INTERRUPT_LEVEL_MASK);

    flag_calc u_flag_calc
    (
        .req        (alu_req),
        .cur        (system_flags),
        .next_flags (next_flags)
    );

    // memory timing; bit 0 reads zero
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            external_memory_timing <= RST_EXTERNAL_MEMORY_TIMING;
        end
        else if (wr_ok && hit_emt)
        begin
            external_memory_timing <= {reg_req.wdata[7:1], 1'b0};
        end
    end

    // decoded memory timing controls
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mem_cfg <= '0;
        end
        else
        begin
            mem_cfg.wait_input_enable <= external_memory_timing[EMT_WAIT_INPUT_BIT];
            // R1 slow timing select
            mem_cfg.slow_timing       <= external_memory_timing[EMT_SLOW_BIT];
            // R2 program wait field
            mem_cfg.prog_wait <= external_memory_timing[EMT_PROG_WAIT_HI:EMT_PROG_WAIT_LO];
            // R3 data wait field
            mem_cfg.data_wait <= external_memory_timing[EMT_DATA_WAIT_HI:EMT_DATA_WAIT_LO];
            // R4 stack area select
            mem_cfg.stack_external    <= external_memory_timing[EMT_STACK_BIT];
        end
    end

    // wait cycles; slow adds one
    always_comb
    begin
        // R2 program access wait
        wait_base = {1'b0, external_memory_timing[EMT_PROG_WAIT_HI:EMT_PROG_WAIT_LO]};
        if (mem_req.is_data)
        begin
            // R3 data access wait
            wait_base = {1'b0, external_memory_timing[EMT_DATA_WAIT_HI:EMT_DATA_WAIT_LO]};
        end
        wait_need = wait_base;
        if (external_memory_timing[EMT_SLOW_BIT])
        begin
            // R1 slow timing adds a cycle
            wait_need = wait_base + SLOW_EXTRA_WAIT;
        end
    end

    // wait-state sequencer
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wait_state <= ST_IDLE;
            wait_count <= 3'h0;
            mem_stall  <= 1'b0;
        end
        else
        begin
            case (wait_state)
                ST_IDLE:
                begin
                    if (mem_req.start && (wait_need != 3'h0))
                    begin
                        wait_state <= ST_WAIT;
                        wait_count <= wait_need;
                        mem_stall  <= 1'b1;
                    end
                end
                ST_WAIT:
                begin
                    wait_count <= wait_count - 3'h1;
                    if (wait_count == 3'h1)
                    begin
                        wait_state <= ST_IDLE;
                        mem_stall  <= 1'b0;
                    end
                end
                default:
                    wait_state <= ST_IDLE;
            endcase
        end
    end

    // arithmetic flags; write beats alu
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            {system_flags.carry, system_flags.zero, system_flags.sign,
             system_flags.overflow, system_flags.decimal, system_flags.half}
                <= RST_SYSTEM_FLAGS[7:2];
        end
        else if (wr_ok && hit_flags)
        begin
            {system_flags.carry, system_flags.zero, system_flags.sign,
             system_flags.overflow, system_flags.decimal, system_flags.half}
                <= reg_req.wdata[7:2];
        end
        else
        begin
            // R7 R8 R9 carry, zero, sign
            system_flags.carry    <= next_flags.carry;
            system_flags.zero     <= next_flags.zero;
            system_flags.sign     <= next_flags.sign;
            // R10 R11 R12 overflow, decimal, half
            system_flags.overflow <= next_flags.overflow;
            system_flags.decimal  <= next_flags.decimal;
            system_flags.half     <= next_flags.half;
        end
    end

    // fast service flag; set wins
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            system_flags.fast_service_active_flag <= RST_SYSTEM_FLAGS[1];
        end
        else if (fast_irq_enter)
        begin
            // R13 set on fast entry
            system_flags.fast_service_active_flag <= 1'b1;
        end
        else if (interrupt_return_instr)
        begin
            // R13 cleared on return
            system_flags.fast_service_active_flag <= 1'b0;
        end
        else if (wr_ok && hit_flags)
        begin
            system_flags.fast_service_active_flag <= reg_req.wdata[1];
        end
    end

    // bank flag: instructions first, then a direct write
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            system_flags.bank <= RST_SYSTEM_FLAGS[0];
        end
        else if (select_bank_one_instr)
        begin
            // R14 select bank one
            system_flags.bank <= 1'b1;
        end
        else if (select_bank_zero_instr)
        begin
            // R14 select bank zero
            system_flags.bank <= 1'b0;
        end
        else if (wr_ok && hit_flags)
        begin
            system_flags.bank <= reg_req.wdata[0];
        end
    end

    assign flags = system_flags;

    // interrupt level mask
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            interrupt_level_mask <= RST_INTERRUPT_LEVEL_MASK;
        end
        else if (wr_ok && hit_imr)
        begin
            interrupt_level_mask <= reg_req.wdata;
        end
    end

    // R17 per-level enable gate
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_enabled <= '0;
        end
        else
        begin
            for (int n = 0; n < IRQ_LEVELS; n++)
            begin
                irq_enabled[n] <= irq_request[n] && (n < 8) && interrupt_level_mask[n % 8];
            end
        end
    end

    // pointer bytes; core load wins
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            instr_pointer_high <= RST_INSTR_POINTER_HIGH;
            instr_pointer_low  <= RST_INSTR_POINTER_LOW;
        end
        else if (ip_load)
        begin
            // R16 upper byte from bits 15:8
            instr_pointer_high <= ip_value[15:8];
            instr_pointer_low  <= ip_value[7:0];
        end
        else if (wr_ok && hit_iph)
        begin
            instr_pointer_high <= reg_req.wdata;
        end
        else if (wr_ok && hit_ipl)
        begin
            instr_pointer_low <= reg_req.wdata;
        end
    end

    // R16 pointer assembled from both bytes
    assign instr_pointer = {instr_pointer_high, instr_pointer_low};

    // read mux; refused reads zero
    always_comb
    begin
        next_rdata = READ_EMPTY;
        if (rd_ok)
        begin
            if (hit_emt)
            begin
                next_rdata = external_memory_timing;
            end
            else if (hit_flags)
            begin
                next_rdata = system_flags;
            end
            else if (hit_iph)
            begin
                next_rdata = instr_pointer_high;
            end
            else if (hit_ipl)
            begin
                next_rdata = instr_pointer_low;
            end
            else if (hit_imr)
            begin
                next_rdata = interrupt_level_mask;
            end
        end
    end

    // answer one cycle after any read
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end
        else
        begin
            reg_rdata  <= next_rdata;
            reg_rvalid <= reg_req.rd;
        end
    end

endmodule

// file: cpu_system_control_registers_properties.sv
// port-level checks for the system control registers
module cpu_system_control_registers_properties
    import sysctl_pkg::*;
#(
    parameter int IRQ_LEVELS = 8
)
(
    input wire logic                  mclk,
    input wire logic                  arst_n,
    input wire sysctl_pkg::reg_req_t  reg_req,
    input wire logic [7:0]            reg_rdata,
    input wire logic                  reg_rvalid,
    input wire sysctl_pkg::alu_req_t  alu_req,
    input wire logic                  fast_irq_enter,
    input wire logic                  select_bank_one_instr,
    input wire logic                  ip_load,
    input wire logic [15:0]           ip_value,
    input wire logic [15:0]           instr_pointer,
    input wire logic [IRQ_LEVELS-1:0] irq_request,
    input wire logic [IRQ_LEVELS-1:0] irq_enabled,
    input wire sysctl_pkg::mem_req_t  mem_req,
    input wire sysctl_pkg::mem_cfg_t  mem_cfg,
    input wire logic                  mem_stall,
    input wire sysctl_pkg::flags_t    flags
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       wrf;
    logic [8:0] sum;
    logic [8:0] dif;
    logic [2:0] need;
    // flags write beats alu
    assign wrf = reg_req.wr && reg_req.mode == MODE_REGISTER && reg_req.addr == OFS_SYSTEM_FLAGS;
    assign sum = {1'b0, alu_req.a} + {1'b0, alu_req.b} + {8'h00, alu_req.cin};
    assign dif = {1'b0, alu_req.a} - {1'b0, alu_req.b} - {8'h00, alu_req.cin};
    assign need = {1'b0, mem_req.is_data ? mem_cfg.data_wait : mem_cfg.prog_wait}
                + {2'b00, mem_cfg.slow_timing};
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);

    property p_rd_answer;
        reg_req.rd |=> reg_rvalid;
    endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("read strobe without answer");
    property p_refused;
        reg_req.rd && reg_req.mode != MODE_REGISTER |=> reg_rvalid && reg_rdata == READ_EMPTY;
    endproperty
    a_refused: assert property (p_refused)
        else $error("non-register read returned data");
    property p_carry_add;
        alu_req.kind == OP_ADD && !wrf |=> flags.carry == $past(sum[8]) && !flags.decimal;
    endproperty
    a_carry_add: assert property (p_carry_add)
        else $error("add carry wrong");
    property p_logic;
        alu_req.kind == OP_LOGIC && !wrf |=> flags.zero == ($past(alu_req.a) == 8'h00)
            && flags.sign == $past(alu_req.a[7]) && !flags.overflow;
    endproperty
    a_logic: assert property (p_logic)
        else $error("logic result flags wrong");
    property p_sub;
        alu_req.kind == OP_SUB && !wrf |=> flags.decimal && flags.carry == $past(dif[8]);
    endproperty
    a_sub: assert property (p_sub)
        else $error("subtract flags wrong");
    property p_fast_set;
        fast_irq_enter |=> flags.fast_service_active_flag;
    endproperty
    a_fast_set: assert property (p_fast_set)
        else $error("fast service flag not set");
    property p_bank_one;
        select_bank_one_instr |=> flags.bank;
    endproperty
    a_bank_one: assert property (p_bank_one)
        else $error("bank one not selected");
    property p_ip;
        ip_load |=> instr_pointer == $past(ip_value);
    endproperty
    a_ip: assert property (p_ip)
        else $error("pointer load wrong");
    property p_irq;
        (irq_enabled & ~$past(irq_request)) == '0;
    endproperty
    a_irq: assert property (p_irq)
        else $error("level enabled without request");
    property p_stall;
        mem_req.start && !mem_stall && need == 3'd4 |=> mem_stall [*4] ##1 !mem_stall;
    endproperty
    a_stall: assert property (p_stall)
        else $error("slow wait length wrong");
endmodule

// file: tb_cpu_system_control_registers.sv
// directed bench for the cpu system control registers
module tb_cpu_system_control_registers;
    timeunit 1ns;
    timeprecision 1ps;
    import sysctl_pkg::*;
    logic        mclk = 1'b0;
    logic        arst_n = 1'b0;
    reg_req_t    reg_req = '0;
    alu_req_t    alu_req = '0;
    mem_req_t    mem_req = '0;
    logic [4:0]  ctl = '0;
    logic [15:0] ip_value = 16'habcd;
    logic [7:0]  irq_request = '0;
    mem_cfg_t    mem_cfg;
    logic [7:0]  reg_rdata;
    logic        reg_rvalid;
    logic [7:0]  irq_enabled;
    logic        mem_stall;
    flags_t      flags;
    logic [15:0] instr_pointer;
    int          num_errors = 0;
    int          check_count = 0;

    always #5 mclk = ~mclk;

    cpu_system_control_registers #(.IRQ_LEVELS(8)) u_cpu_system_control_registers
    (
        .mclk                   (mclk),
        .arst_n                 (arst_n),
        .reg_req                (reg_req),
        .mem_cfg                (mem_cfg),
        .reg_rdata              (reg_rdata),
        .reg_rvalid             (reg_rvalid),
        .alu_req                (alu_req),
        .fast_irq_enter         (ctl[0]),
        .interrupt_return_instr (ctl[1]),
        .select_bank_zero_instr (ctl[2]),
        .select_bank_one_instr  (ctl[3]),
        .ip_load                (ctl[4]),
        .ip_value               (ip_value),
        .irq_request            (irq_request),
        .irq_enabled            (irq_enabled),
        .mem_req                (mem_req),
        .mem_stall              (mem_stall),
        .flags                  (flags),
        .instr_pointer          (instr_pointer)
    );

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        check_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic bus(input logic w, input addr_mode_t m, input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_req <= '{wr: w, rd: !w, mode: m, addr: a, wdata: d};
        @(posedge mclk);
        reg_req <= '0;
        #1;
    endtask

    task automatic rd(input addr_mode_t m, input logic [7:0] a, input logic [7:0] e, input string s);
        bus(1'b0, m, a, 8'h00);
        chk({15'h0, reg_rvalid}, 16'h0001, "read answer");
        chk({8'h0, reg_rdata}, {8'h0, e}, s);
    endtask

    // one-cycle strobe on the control inputs; bits: fast, return, bank0, bank1, load
    task automatic pulse(input logic [4:0] v);
        @(posedge mclk);
        ctl <= v;
        @(posedge mclk);
        ctl <= '0;
        #1;
    endtask

    task automatic alu(input alu_kind_t k, input logic [7:0] a, input logic [7:0] b,
                       input logic c, input logic [7:0] e);
        @(posedge mclk);
        alu_req <= '{kind: k, a: a, b: b, cin: c};
        @(posedge mclk);
        alu_req <= '0;
        #1;
        chk({8'h0, flags}, {8'h0, e}, "flags");
    endtask

    task automatic t_reset();
        chk({8'h0, flags}, 16'h0000, "reset flags");
        chk({9'h0, mem_cfg}, 16'h003e, "reset timing decode");
        rd(MODE_REGISTER, OFS_EXTERNAL_MEMORY_TIMING, 8'h7c, "reset timing");
        rd(MODE_REGISTER, 8'hd6, 8'h00, "unmapped");
    endtask

    task automatic t_ctrl();
        pulse(5'h01);
        chk({15'h0, flags.fast_service_active_flag}, 16'h1, "fast set");
        pulse(5'h02);
        chk({15'h0, flags.fast_service_active_flag}, 16'h0, "fast clear");
        pulse(5'h08);
        chk({15'h0, flags.bank}, 16'h1, "bank one");
        rd(MODE_REGISTER, OFS_EXTERNAL_MEMORY_TIMING, 8'h00, "timing hidden");
        bus(1'b1, MODE_REGISTER, OFS_EXTERNAL_MEMORY_TIMING, 8'h00);
        pulse(5'h04);
        chk({15'h0, flags.bank}, 16'h0, "bank zero");
        rd(MODE_REGISTER, OFS_EXTERNAL_MEMORY_TIMING, 8'h7c, "timing kept");
    endtask

    task automatic t_alu();
        alu(OP_ADD, 8'h7f, 8'h01, 1'b0, 8'h34);
        alu(OP_ADD, 8'hff, 8'h01, 1'b0, 8'hc4);
        alu(OP_ADD, 8'h0e, 8'h01, 1'b1, 8'h04);
        alu(OP_SUB, 8'h00, 8'h01, 1'b0, 8'hac);
        alu(OP_SUB, 8'h80, 8'h01, 1'b0, 8'h1c);
        alu(OP_LOGIC, 8'h00, 8'h00, 1'b0, 8'h4c);
        alu(OP_LOGIC, 8'h80, 8'h00, 1'b0, 8'h2c);
        rd(MODE_REGISTER, OFS_SYSTEM_FLAGS, 8'h2c, "flags read");
        bus(1'b1, MODE_REGISTER, OFS_SYSTEM_FLAGS, 8'h00);
    endtask

    // fields differ between program and data for i = 1, 2, 5 and 6, so a wrong pick shows
    task automatic t_wait();
        logic [7:0] v;
        logic [2:0] need;
        int         n;
        for (int i = 0; i < 8; i++)
        begin
            v = {1'b0, i[2], i[1:0], i[0], i[1], i[0], 1'b0};
            need = {1'b0, i[0] ? {i[0], i[1]} : i[1:0]} + {2'b00, i[2]};
            bus(1'b1, MODE_REGISTER, OFS_EXTERNAL_MEMORY_TIMING, v);
            @(posedge mclk);
            #1;
            chk({9'h0, mem_cfg}, {9'h0, v[7:1]}, "timing fields");
            @(posedge mclk);
            mem_req <= '{start: 1'b1, is_data: i[0]};
            @(posedge mclk);
            mem_req <= '0;
            n = 0;
            #1;
            while (mem_stall === 1'b1 && n < 9)
            begin
                n++;
                @(posedge mclk);
                #1;
            end
            chk(16'(n), {13'h0, need}, "wait cycles");
        end
        bus(1'b1, MODE_REGISTER, OFS_EXTERNAL_MEMORY_TIMING, 8'h00);
    endtask

    task automatic t_mode();
        bus(1'b1, MODE_REGISTER, OFS_INTERRUPT_LEVEL_MASK, 8'h5a);
        bus(1'b1, MODE_INDIRECT, OFS_INTERRUPT_LEVEL_MASK, 8'hff);
        bus(1'b1, MODE_INDEXED, OFS_INTERRUPT_LEVEL_MASK, 8'hff);
        rd(MODE_INDIRECT, OFS_INTERRUPT_LEVEL_MASK, 8'h00, "indirect");
        rd(MODE_INDEXED, OFS_INTERRUPT_LEVEL_MASK, 8'h00, "indexed");
        rd(MODE_REGISTER, OFS_INTERRUPT_LEVEL_MASK, 8'h5a, "mask");
        @(posedge mclk);
        irq_request <= 8'hff;
        for (int i = 0; i < 8; i++)
        begin
            bus(1'b1, MODE_REGISTER, OFS_INTERRUPT_LEVEL_MASK, 8'h01 << i);
            @(posedge mclk);
            #1;
            chk({8'h0, irq_enabled}, 16'h0001 << i, "level enable");
        end
    endtask

    task automatic t_ip();
        bus(1'b1, MODE_REGISTER, OFS_INSTR_POINTER_HIGH, 8'h12);
        bus(1'b1, MODE_REGISTER, OFS_INSTR_POINTER_LOW, 8'h34);
        chk(instr_pointer, 16'h1234, "pointer bytes");
        pulse(5'h10);
        rd(MODE_REGISTER, OFS_INSTR_POINTER_HIGH, 8'hab, "pointer high");
        rd(MODE_REGISTER, OFS_INSTR_POINTER_LOW, 8'hcd, "pointer low");
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        repeat (16) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        t_reset();
        t_ctrl();
        t_alu();
        t_wait();
        t_mode();
        t_ip();
        conclude();
    end

    // hang guard; run takes ~1.6us
    initial
    begin
        #50us;
        num_errors++;
        conclude();
    end
endmodule

bind cpu_system_control_registers cpu_system_control_registers_properties
    #(.IRQ_LEVELS(IRQ_LEVELS)) u_cpu_system_control_registers_properties
(
    .mclk(mclk),
    .arst_n(arst_n),
    .reg_req(reg_req),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid),
    .alu_req(alu_req),
    .fast_irq_enter(fast_irq_enter),
    .select_bank_one_instr(select_bank_one_instr),
    .ip_load(ip_load),
    .ip_value(ip_value),
    .instr_pointer(instr_pointer),
    .irq_request(irq_request),
    .irq_enabled(irq_enabled),
    .mem_req(mem_req),
    .mem_cfg(mem_cfg),
    .mem_stall(mem_stall),
    .flags(flags)
);
